// *** swt_top.sv ***
// slow wake timer pair with wishbone register access
// Functional notes
// - two timers, index zero or one, 41 bits
// - counters advance once per slow clock cycle
// - timers count while processor runs too
// - slow clock source selection kept through sleep
// - per-timer interrupt enable raises request on timeout
// - writing enable control halts running timer
// - new enable applies from next start
// - enabled expiry during sleep gives wake event
// - disabled expiry during sleep never wakes
// - interrupt leaves on system controller source
// - start loads tick count and runs
// - count read returns lower 32 bits
// - stop halts counter, raises no interrupt
// - count down, fire at zero, reload, continue
// - fired flags per timer, cleared by read
// - active flag stays set after rollover
//
// The Wishbone slave port and the address map were chosen for this implementation.
module swt_top #(
  parameter int NUM_TIMERS = swt_pkg::NUM_TIMERS,
  parameter int CNT_W = swt_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [swt_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [swt_pkg::DATA_W-1:0] wb_wdat,
  output logic [swt_pkg::DATA_W-1:0] wb_rdat,
  output logic wb_ack,
  input wire logic slow_clk_rc,
  input wire logic slow_clk_xtal,
  input wire logic sleep_mode,
  output logic sysctrl_irq,
  output logic wake_event
);
  import swt_pkg::*;

  logic ack_q;
  logic [DATA_W-1:0] rdat_q;
  logic [DATA_W-1:0] rdat_d;
  logic req;
  logic wr;
  logic rd;
  logic glb_hit_fired;
  logic sel_active;
  logic sel_fired;
  logic sel_mask;
  logic sel_clk;
  logic [NUM_TIMERS-1:0] tmr_hit;
  logic [NUM_TIMERS-1:0] irq_fire;
  logic [NUM_SRC-1:0] src_pin;
  logic [2:0] sync_q [NUM_SRC];
  logic [NUM_SRC-1:0] lvl_q;
  logic lvl_prev_q;
  logic slow_tick;
  logic clk_sel_q;
  logic [NUM_TIMERS-1:0] mask_q;
  logic [NUM_TIMERS-1:0] fired_q;
  logic [NUM_TIMERS-1:0] irq_pend_q;
  logic [NUM_TIMERS-1:0] active;
  logic [NUM_TIMERS-1:0] fire;
  logic [NUM_TIMERS-1:0] ien_run_q;
  logic [NUM_TIMERS-1:0] ien_cfg_q;
  logic [CNT_W-1:0] count [NUM_TIMERS];
  logic [CNT_W-1:0] start_val_q [NUM_TIMERS];
  logic wake_q;

  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0] sel
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // bus request decode
  assign req = wb_cyc && wb_stb && !ack_q;
  assign wr = req && wb_we;
  assign rd = req && !wb_we;

  // global register selects
  assign sel_active = (wb_adr == REG_ACTIVE);
  assign sel_fired = (wb_adr == REG_FIRED);
  assign sel_mask = (wb_adr == REG_IRQ_MASK);
  assign sel_clk = (wb_adr == REG_CLK_SEL);
  assign glb_hit_fired = rd && sel_fired;
  assign wb_ack = ack_q;
  assign wb_rdat = rdat_q;

  // ack one cycle after request, dropped the next
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // slow clock pins through three flops each
  assign src_pin[0] = slow_clk_rc;
  assign src_pin[1] = slow_clk_xtal;

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_sync
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        sync_q[s] <= 3'h0;
      end else begin
        sync_q[s] <= {sync_q[s][1:0], src_pin[s]};
      end
    end

    // level accepted once second and third stage agree
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        lvl_q[s] <= 1'b0;
      end else if (sync_q[s][1] == sync_q[s][2]) begin
        lvl_q[s] <= sync_q[s][2];
      end
    end
  end

  // rising edge of the selected slow clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_prev_q <= 1'b0;
    end else begin
      lvl_prev_q <= lvl_q[clk_sel_q];
    end
  end

  assign slow_tick = lvl_q[clk_sel_q] && !lvl_prev_q;

  // source selection; sleep never touches it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_sel_q <= CLK_SEL_RESET;
    end else if (wr && sel_clk && wb_sel[0]) begin
      clk_sel_q <= wb_wdat[CLK_SEL_BIT];
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= IRQ_MASK_RESET;
    end else if (wr && sel_mask && wb_sel[0]) begin
      mask_q <= wb_wdat[NUM_TIMERS-1:0];
    end
  end

  // per-timer registers and counter
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_tmr
    localparam logic [ADDR_W-1:0] BASE = ADDR_W'(TMR_BASE + i * TMR_STRIDE);
    logic hit;
    logic wr_lo;
    logic wr_hi;
    logic wr_cfg;
    logic wr_cmd;
    logic start;
    logic stop;
    logic halt;
    logic [DATA_W-1:0] lo_merged;
    logic [DATA_W-1:0] hi_merged;

    assign hit = (wb_adr[ADDR_W-1:4] == BASE[ADDR_W-1:4]);
    assign wr_lo = wr && hit && (wb_adr[3:0] == TMR_COUNT_LO);
    assign wr_hi = wr && hit && (wb_adr[3:0] == TMR_START_HI);
    assign wr_cfg = wr && hit && (wb_adr[3:0] == TMR_CFG) && wb_sel[0];
    assign wr_cmd = wr && hit && (wb_adr[3:0] == TMR_CMD) && wb_sel[0];
    assign start = wr_cmd && wb_wdat[CMD_START_BIT];
    assign stop = wr_cmd && wb_wdat[CMD_STOP_BIT] && !start;
    assign halt = stop || (wr_cfg && active[i]);
    assign tmr_hit[i] = hit;

    // byte-lane merge of the start count words
    assign lo_merged = merge_bytes(start_val_q[i][DATA_W-1:0], wb_wdat, wb_sel);
    assign hi_merged = merge_bytes(DATA_W'(start_val_q[i][CNT_W-1:DATA_W]), wb_wdat, wb_sel);

    // expiry that may raise a request
    assign irq_fire[i] = fire[i] && ien_run_q[i];

    // start tick count held for the next start
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        start_val_q[i] <= CNT_RESET;
      end else if (wr_lo) begin
        start_val_q[i][DATA_W-1:0] <= lo_merged;
      end else if (wr_hi) begin
        start_val_q[i][CNT_W-1:DATA_W] <= hi_merged[HI_W-1:0];
      end
    end

    // expiry_irq_enable as written by software
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        ien_cfg_q[i] <= IEN_RESET;
      end else if (wr_cfg) begin
        ien_cfg_q[i] <= wb_wdat[CFG_IEN_BIT];
      end
    end

    // enable captured only at start
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        ien_run_q[i] <= IEN_RESET;
      end else if (start) begin
        ien_run_q[i] <= ien_cfg_q[i];
      end
    end

    swt_counter #(
      .CNT_W(CNT_W),
      .RELOAD(CNT_RELOAD)
    ) u_cnt (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .tick(slow_tick),
      .load(start),
      .load_val(start_val_q[i]),
      .halt(halt),
      .count_q(count[i]),
      .active(active[i]),
      .fire_q(fire[i])
    );

    // fired flag: set always, cleared by read, set wins
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        fired_q[i] <= 1'b0;
      end else begin
        fired_q[i] <= (fired_q[i] && !glb_hit_fired) || fire[i];
      end
    end

    // interrupt pending only with captured enable
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        irq_pend_q[i] <= 1'b0;
      end else begin
        irq_pend_q[i] <= (irq_pend_q[i] && !glb_hit_fired) || irq_fire[i];
      end
    end
  end

  // interrupt on the system controller source
  assign sysctrl_irq = |(irq_pend_q & mask_q);

  // wake event pulse for enabled expiry during sleep
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= sleep_mode && |irq_fire;
    end
  end

  assign wake_event = wake_q;

  // read data mux
  always_comb begin
    rdat_d = DATA_ZERO;
    if (sel_active) begin
      rdat_d[NUM_TIMERS-1:0] = active;
    end else if (sel_fired) begin
      rdat_d[NUM_TIMERS-1:0] = fired_q;
    end else if (sel_mask) begin
      rdat_d[NUM_TIMERS-1:0] = mask_q;
    end else if (sel_clk) begin
      rdat_d[CLK_SEL_BIT] = clk_sel_q;
    end else begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (tmr_hit[t]) begin
          case (wb_adr[3:0])
            TMR_COUNT_LO: rdat_d = count[t][DATA_W-1:0];
            TMR_START_HI: rdat_d[HI_W-1:0] = start_val_q[t][CNT_W-1:DATA_W];
            TMR_CFG: rdat_d[CFG_IEN_BIT] = ien_cfg_q[t];
            TMR_CMD: rdat_d[CMD_START_BIT] = active[t];
            default: rdat_d = DATA_ZERO;
          endcase
        end
      end
    end
  end

  // read data registered with the ack
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdat_q <= DATA_ZERO;
    end else if (rd) begin
      rdat_q <= rdat_d;
    end
  end
endmodule

// *** swt_pkg.sv ***
// constants, offsets and types for the slow wake timer pair
package swt_pkg;
  localparam int NUM_TIMERS = 2;
  localparam int CNT_W = 41;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int HI_W = CNT_W - DATA_W;
  localparam int NUM_SRC = 2;

  // timer selection indices
  localparam int SLOW_TIMER_INDEX_ZERO = 0;
  localparam int SLOW_TIMER_INDEX_ONE = 1;

  // rollover value after passing zero
  localparam logic [CNT_W-1:0] CNT_RELOAD = 41'h1f_ffff_ffff;
  localparam logic [CNT_W-1:0] CNT_RESET = 41'h000_0000_0000;

  // nominal slow clock and system clock rates in hertz
  localparam int SLOW_CLK_HZ = 32000;
  localparam int SYS_CLK_HZ = 200000000;

  // global register byte offsets
  localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FIRED = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CLK_SEL = 8'h0c;
  // per timer block: base + index * stride
  localparam logic [ADDR_W-1:0] TMR_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] TMR_STRIDE = 8'h10;
  localparam logic [3:0] TMR_COUNT_LO = 4'h0;
  localparam logic [3:0] TMR_START_HI = 4'h4;
  localparam logic [3:0] TMR_CFG = 4'h8;
  localparam logic [3:0] TMR_CMD = 4'hc;

  // field positions
  localparam int CFG_IEN_BIT = 0;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CLK_SEL_BIT = 0;

  // reset values
  localparam logic [NUM_TIMERS-1:0] IRQ_MASK_RESET = 2'h3;
  localparam logic CLK_SEL_RESET = 1'b0;
  localparam logic IEN_RESET = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    SWT_IDLE = 2'b01,
    SWT_RUN = 2'b10
  } swt_run_state_t;
endpackage

// *** swt_counter.sv ***
// one 41-bit down-counter of the wake timer pair
module swt_counter #(
  parameter int CNT_W = swt_pkg::CNT_W,
  parameter logic [CNT_W-1:0] RELOAD = swt_pkg::CNT_RELOAD
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  input wire logic halt,
  output logic [CNT_W-1:0] count_q,
  output logic active,
  output logic fire_q
);
  import swt_pkg::*;

  swt_run_state_t state_q;
  logic at_zero;

  assign at_zero = (count_q == '0);
  assign active = (state_q == SWT_RUN);

  // run state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= SWT_IDLE;
    end else begin
      case (state_q)
        SWT_IDLE: begin
          if (load) begin
            state_q <= SWT_RUN;
          end
        end
        SWT_RUN: begin
          if (load) begin
            state_q <= SWT_RUN;
          end else if (halt) begin
            state_q <= SWT_IDLE;
          end
        end
        default: begin
          state_q <= SWT_IDLE;
        end
      endcase
    end
  end

  // count down on each slow tick, roll over at zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (active && tick) begin
      if (at_zero) begin
        count_q <= RELOAD;
      end else begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // fire pulse; state stays running after rollover
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= active && tick && at_zero && !load && !halt;
    end
  end
endmodule

// *** swt_top_props.sv ***
// bus and interrupt port properties for the wake timer pair
module swt_top_props #(
  parameter int NUM_TIMERS = 2,
  parameter int CNT_W = 41
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [swt_pkg::ADDR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [swt_pkg::DATA_W-1:0] wb_wdat,
  input wire logic [swt_pkg::DATA_W-1:0] wb_rdat,
  input wire logic wb_ack,
  input wire logic slow_clk_rc,
  input wire logic slow_clk_xtal,
  input wire logic sleep_mode,
  input wire logic sysctrl_irq,
  input wire logic wake_event
);
  import swt_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic take;
  assign take = wb_cyc && wb_stb && !wb_ack;
  a_ack_after_take: assert property (take |=> wb_ack)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
    else $error("ack without request");
  a_unmapped_reads_zero: assert property (take && !wb_we && wb_adr == 8'h40 |=>
    wb_rdat == DATA_ZERO) else $error("unmapped read not zero");
  a_wake_needs_sleep: assert property (wake_event |-> $past(sleep_mode))
    else $error("wake outside sleep");
  a_wake_one_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake longer than one cycle");
  a_irq_holds_idle: assert property (sysctrl_irq && !wb_cyc |=> sysctrl_irq)
    else $error("irq dropped without access");
  a_fired_read_clears: assert property (take && !wb_we && wb_adr == REG_FIRED |=>
    !sysctrl_irq) else $error("irq kept after fired read");
endmodule
bind swt_top swt_top_props #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) u_props (
  .ref_clk(ref_clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat), .wb_ack(wb_ack),
  .slow_clk_rc(slow_clk_rc), .slow_clk_xtal(slow_clk_xtal), .sleep_mode(sleep_mode),
  .sysctrl_irq(sysctrl_irq), .wake_event(wake_event));

// *** testbench.sv ***
// self-checking bench for the wake timer pair
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import swt_pkg::*;
  logic ref_clk = 0, resetn = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack, slow_clk_rc = 0;
  logic sleep_mode = 0, sysctrl_irq, wake_event, slow_clk_xtal = 0, xsel = 0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  int fails = 0, cmp_count = 0, wake_cnt = 0;
  swt_top uut (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat), .wb_rdat(wb_rdat),
    .wb_ack(wb_ack), .slow_clk_rc(slow_clk_rc), .slow_clk_xtal(slow_clk_xtal),
    .sleep_mode(sleep_mode), .sysctrl_irq(sysctrl_irq), .wake_event(wake_event));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wake_event === 1'b1) wake_cnt++;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge ref_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'b11, we, adr, 4'hf, dat};
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (wb_ack === 1'b1) break;
    end
    rd = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    if (n == 20) begin
      fails++;
      $display("wrong value at %0t: bus ack timeout", $time);
      summarize();
    end
  endtask
  // slow clock at a fixed pace, so no calibration is needed
  task automatic tick(input int k);
    repeat (k) begin
      slow_clk_rc <= !xsel;
      slow_clk_xtal <= xsel;
      repeat (8) @(posedge ref_clk);
      slow_clk_rc <= 1'b0;
      slow_clk_xtal <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  task automatic start(input logic [7:0] b, input logic ien, input logic [31:0] cnt);
    bus(1, b + 8'h08, {31'h0, ien});
    bus(1, b, cnt);
    bus(1, b + 8'h04, 32'h0000_0000);
    bus(1, b + 8'h0c, 32'h0000_0001);
  endtask
  task automatic t_reset();
    bus(0, REG_IRQ_MASK, 0); chk(rd, 32'h0000_0003, "mask reset");
    bus(0, REG_ACTIVE, 0); chk(rd, 32'h0000_0000, "active reset");
    bus(1, REG_CLK_SEL, 32'h0000_0001); bus(0, REG_CLK_SEL, 0); chk(rd, 32'h1, "clk sel");
    bus(1, REG_CLK_SEL, 32'h0000_0000);
    bus(1, 8'h40, 32'h0000_00a5); bus(0, 8'h40, 0); chk(rd, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_expire();
    sleep_mode <= 1'b1;
    start(8'h10, 1, 32'h0000_0002);
    bus(0, REG_ACTIVE, 0); chk(rd, 32'h0000_0001, "active after start");
    tick(2); bus(0, 8'h10, 0); chk(rd, 32'h0000_0000, "count at zero");
    bus(0, REG_FIRED, 0); chk(rd, 32'h0, "no fire yet");
    tick(1); chk({31'h0, sysctrl_irq}, 32'h1, "irq on expiry");
    chk(wake_cnt, 1, "wake in sleep");
    bus(0, 8'h10, 0); chk(rd, 32'hffff_ffff, "reload low word");
    bus(0, REG_FIRED, 0); chk(rd, 32'h1, "fired flag");
    bus(0, REG_FIRED, 0); chk(rd, 32'h0, "fired cleared");
    bus(0, 8'h1c, 0); chk(rd, 32'h1, "active after roll");
    $display("test expire done");
  endtask
  task automatic t_noirq();
    start(8'h20, 0, 32'h0000_0002);
    tick(3); chk({31'h0, sysctrl_irq}, 32'h0, "irq gated");
    chk(wake_cnt, 1, "no wake");
    bus(0, REG_FIRED, 0); chk(rd, 32'h2, "fired without irq");
    bus(1, 8'h2c, 32'h0000_0002); bus(0, 8'h20, 0); tick(2);
    bus(0, 8'h20, 0); chk(rd, 32'hffff_ffff, "stop halts");
    bus(0, REG_ACTIVE, 0); chk(rd, 32'h1, "stop active");
    bus(1, 8'h18, 32'h0000_0000); bus(0, REG_ACTIVE, 0); chk(rd, 32'h0, "cfg halts");
    $display("test disabled and stop done");
  endtask
  task automatic t_mask();
    sleep_mode <= 1'b0;
    start(8'h20, 1, 32'h0000_0002);
    bus(1, REG_IRQ_MASK, 32'h0000_0000);
    tick(3); chk({31'h0, sysctrl_irq}, 32'h0, "masked irq");
    bus(1, REG_IRQ_MASK, 32'h0000_0003); chk({31'h0, sysctrl_irq}, 32'h1, "unmask");
    chk(wake_cnt, 1, "awake no wake");
    bus(0, REG_FIRED, 0); chk({31'h0, sysctrl_irq}, 32'h0, "read clears irq");
    $display("test mask done");
  endtask
  task automatic t_xtal();
    bus(1, REG_CLK_SEL, 32'h0000_0001); sleep_mode <= 1'b1;
    start(8'h10, 1, 32'h0000_0005);
    tick(1); bus(0, 8'h10, 0); chk(rd, 32'h0000_0005, "rc ignored on xtal");
    xsel = 1'b1;
    tick(2); bus(0, 8'h10, 0); chk(rd, 32'h0000_0003, "xtal ticks in sleep");
    bus(0, REG_CLK_SEL, 0); chk(rd, 32'h0000_0001, "selection kept");
    bus(1, 8'h1c, 32'h0000_0002); tick(4); chk({31'h0, sysctrl_irq}, 32'h0, "stop no irq");
    chk(wake_cnt, 1, "stop no wake");
    bus(0, 8'h10, 0); chk(rd, 32'h0000_0003, "xtal count halted");
    xsel = 1'b0;
    bus(1, REG_CLK_SEL, 32'h0000_0000); sleep_mode <= 1'b0;
    $display("test clock select done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_expire();
    t_noirq();
    t_mask();
    t_xtal();
    summarize();
  end
endmodule
